// >>> pkg/rss_pkg.sv
// Package for the reset source sequencer: timing counts, address map, carriers.
// Assumes one 20 MHz bus clock; every count is in bus cycles.
package rss_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // Oscillator stabilisation delay, in bus cycles
  localparam logic [11:0] STAB_SHORT_CYC = 12'h010;
  localparam logic [11:0] STAB_LONG_CYC = 12'hfe0;

  // Least pin pulldown time, three to four cycles, held to four
  localparam logic [2:0] PULLDOWN_MIN_CYC = 3'h4;

  // Legal opcode fetch windows
  localparam logic [15:0] PROG_LO = 16'h0700;
  localparam logic [15:0] PROG_HI = 16'h1fff;
  localparam logic [15:0] RAM_LO = 16'h0020;
  localparam logic [15:0] RAM_HI = 16'h00ff;

  // One-time option bits
  typedef struct packed {
    logic long_delay;
    logic watchdog_enable_option;
    logic low_voltage_enable_option;
  } rss_options_t;

  // Opcode fetch strobe with its address
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } rss_fetch_t;

  // Which sources hold the internal reset
  typedef struct packed {
    logic power_up;
    logic pin;
    logic watchdog;
    logic low_voltage;
    logic illegal_addr;
  } rss_cause_t;

endpackage

// >>> rtl/rss_pulldown.sv
// Reset pin pulldown stretcher: holds the pin low while an internal source
// is active and for at least the minimum count after it starts.
// Assumes source is a synchronous level on clock.
`timescale 1ns/1ps
`default_nettype none
module rss_pulldown
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Internal source level
  input wire logic source,
  // Pulldown drive
  output logic pull_low
);

  logic [2:0] count;
  logic [2:0] next_count;
  logic source_d;
  logic next_source_d;

  always_comb begin
    next_source_d = source;
    next_count = count;
    if (source && !source_d) begin
      next_count = PULLDOWN_MIN_CYC - 3'h1;
    end else if (count != 3'h0) begin
      next_count = count - 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= 3'h0;
      source_d <= 1'b0;
    end else begin
      count <= next_count;
      source_d <= next_source_d;
    end
  end

  // Longer of source duration or four cycles from its start
  assign pull_low = source || (count != 3'h0);

endmodule
`default_nettype wire

// >>> rtl/rss_sequencer.sv
// Reset source sequencer: merges power-up, pin, watchdog, low-voltage and
// illegal-fetch sources into one internal reset for CPU and peripherals.
// Assumes all inputs are synchronous to clock except the reset pin, which
// is double-registered here; rst models the power-on condition of the logic.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Internal reset stops the CPU; release lets it fetch the reset vector.
// - A rising supply on the power-up detect input starts power-up reset.
// - Power-up reset ignores supply drops; brown-out belongs to low-voltage reset.
// - Power-up holds reset 16 or 4064 cycles after oscillator starts, by option.
// - Power-up reset drives the internal reset.
// - Pin still low after the delay keeps reset until pin goes high.
// - Any other source active after the delay keeps reset until all end.
// - Low pin asserts internal reset until the pin returns high.
// - Watchdog, low-voltage, illegal fetch pull pin low, longer of source or 4.
// - Power-up reset never drives the pin pulldown.
// - Watchdog timeout is a reset source.
// - Fetch outside implemented memory raises illegal-address reset.
// - Legal fetches: 0x0700-0x1fff and 0x0020-0x00ff; others reset.
// - Watchdog source gated by its one-time option bit.
// - Low-voltage source gated by its one-time option bit.
module rss_sequencer
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Supply and oscillator status
  input wire logic power_up_detect,
  input wire logic osc_active,
  // One-time options
  input wire rss_options_t options,
  // Reset pin, open drain
  input wire logic reset_pin_n_in,
  output logic reset_pin_n_out,
  output logic reset_pin_n_oe,
  // Internal sources
  input wire logic watchdog_timeout,
  input wire logic low_voltage_trip,
  input wire rss_fetch_t fetch,
  // Reset to CPU and peripherals
  output logic cpu_reset,
  output logic vector_load,
  output rss_cause_t cause
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  logic pin_meta;
  logic pin_sync;

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= reset_pin_n_in;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal sources
  logic illegal_fetch;
  logic wd_src;
  logic lv_src;
  logic int_src;
  logic pull_low;

  assign illegal_fetch = fetch.valid &&
    !((fetch.addr >= PROG_LO && fetch.addr <= PROG_HI) ||
      (fetch.addr >= RAM_LO && fetch.addr <= RAM_HI));
  assign wd_src = watchdog_timeout && options.watchdog_enable_option;
  assign lv_src = low_voltage_trip && options.low_voltage_enable_option;
  // Power-up is not part of this set
  assign int_src = wd_src || lv_src || illegal_fetch;

  rss_pulldown u_pulldown (
    .clock(clock),
    .rst(rst),
    .source(int_src),
    .pull_low(pull_low)
  );

  assign reset_pin_n_out = 1'b0;
  assign reset_pin_n_oe = pull_low;

  ////////////////////////////////////////////////////////////////////////
  // Power-up sequencer
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT_OSC = 3'b010,
    ST_STAB = 3'b100
  } rss_state_t;

  rss_state_t state;
  rss_state_t next_state;
  logic [11:0] stab_count;
  logic [11:0] next_stab_count;
  logic pud_d;
  logic next_pud_d;
  logic pwr_hold;

  always_comb begin
    next_state = state;
    next_stab_count = stab_count;
    next_pud_d = power_up_detect;
    unique case (state)
      ST_IDLE: begin
        // Only a rising supply starts it; a fall does nothing
        if (power_up_detect && !pud_d) begin
          next_state = ST_WAIT_OSC;
        end
      end
      ST_WAIT_OSC: begin
        if (osc_active) begin
          next_state = ST_STAB;
          next_stab_count = (options.long_delay ? STAB_LONG_CYC : STAB_SHORT_CYC)
            - 12'h001;
        end
      end
      ST_STAB: begin
        if (stab_count == 12'h000) begin
          next_state = ST_IDLE;
        end else begin
          next_stab_count = stab_count - 12'h001;
        end
      end
      default: begin
        next_state = ST_WAIT_OSC;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_WAIT_OSC;
      stab_count <= 12'h000;
      pud_d <= 1'b1;
    end else begin
      state <= next_state;
      stab_count <= next_stab_count;
      pud_d <= next_pud_d;
    end
  end

  assign pwr_hold = (state != ST_IDLE);

  // Cycles spent in the stabilisation state, watched by the delay length check
  logic [12:0] stab_seen;
  logic [12:0] next_stab_seen;

  always_comb begin
    next_stab_seen = 13'h0;
    if (state == ST_STAB) begin
      next_stab_seen = stab_seen + 13'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stab_seen <= 13'h0;
    end else begin
      stab_seen <= next_stab_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset merge and synchronous release
  logic any_reset;
  logic next_cpu_reset;
  logic next_vector_load;
  rss_cause_t next_cause;

  // Pin low or any source keeps reset after the delay ends
  assign any_reset = pwr_hold || !pin_sync || wd_src || lv_src || illegal_fetch
    || pull_low;

  always_comb begin
    next_cpu_reset = any_reset;
    next_vector_load = cpu_reset && !any_reset;
    next_cause.power_up = pwr_hold;
    next_cause.pin = !pin_sync;
    next_cause.watchdog = wd_src;
    next_cause.low_voltage = lv_src;
    next_cause.illegal_addr = illegal_fetch;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_reset <= 1'b1;
      vector_load <= 1'b0;
      cause <= '0;
    end else begin
      cpu_reset <= next_cpu_reset;
      vector_load <= next_vector_load;
      cause <= next_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_stab_hold: assert property (@(posedge clock) disable iff (rst)
    (state == ST_WAIT_OSC && osc_active && !options.long_delay) |=>
      (pwr_hold [*8]))
    else $error("power-up hold ended early");
  chk_pin_reset: assert property (@(posedge clock) disable iff (rst)
    !pin_sync |=> cpu_reset)
    else $error("low pin did not hold reset");
  chk_pin_sync: assert property (@(posedge clock) disable iff (rst)
    (!reset_pin_n_in && !pull_low && !pwr_hold) |=> ##2 cpu_reset)
    else $error("pin reset not seen after sync");
  chk_pulldown_min: assert property (@(posedge clock) disable iff (rst)
    $rose(int_src) |-> reset_pin_n_oe [*4])
    else $error("pulldown shorter than four cycles");
  chk_pulldown_src: assert property (@(posedge clock) disable iff (rst)
    int_src |-> reset_pin_n_oe)
    else $error("pulldown off while source active");
  chk_no_por_pull: assert property (@(posedge clock) disable iff (rst)
    (pwr_hold && !int_src && !$past(int_src) && !$past(int_src, 2)
      && !$past(int_src, 3)) |-> !reset_pin_n_oe)
    else $error("power-up drove the pulldown");
  chk_wd_gate: assert property (@(posedge clock) disable iff (rst)
    (watchdog_timeout && options.watchdog_enable_option) |=> cpu_reset)
    else $error("watchdog timeout missed");
  chk_lv_gate: assert property (@(posedge clock) disable iff (rst)
    !options.low_voltage_enable_option |=> !cause.low_voltage)
    else $error("low-voltage source not gated");
  chk_illegal_map: assert property (@(posedge clock) disable iff (rst)
    (fetch.valid && fetch.addr >= 16'h0100 && fetch.addr <= 16'h06ff) |=>
      (cpu_reset && cause.illegal_addr))
    else $error("illegal fetch did not reset");
  chk_vector_load: assert property (@(posedge clock) disable iff (rst)
    $fell(cpu_reset) |-> vector_load)
    else $error("vector load missing on release");
  chk_pwr_start: assert property (@(posedge clock) disable iff (rst)
    (state == ST_IDLE && power_up_detect && !pud_d) |=> pwr_hold)
    else $error("rising supply did not start power-up");
  chk_supply_drop: assert property (@(posedge clock) disable iff (rst)
    (state == ST_IDLE && !power_up_detect) |=> (state == ST_IDLE))
    else $error("supply drop started power-up");
  chk_wait_osc: assert property (@(posedge clock) disable iff (rst)
    (state == ST_WAIT_OSC && !osc_active) |=> (state == ST_WAIT_OSC))
    else $error("delay started before oscillator");
  chk_stab_length: assert property (@(posedge clock) disable iff (rst)
    (state == ST_STAB && next_state == ST_IDLE) |->
      (stab_seen + 13'h1 == {1'b0, (options.long_delay ? STAB_LONG_CYC : STAB_SHORT_CYC)}))
    else $error("stabilisation delay length wrong");
  chk_pwr_cpu: assert property (@(posedge clock) disable iff (rst)
    pwr_hold |=> (cpu_reset && cause.power_up))
    else $error("power-up hold did not reset the cpu");
  chk_hold_sources: assert property (@(posedge clock) disable iff (rst)
    (pwr_hold || !pin_sync || int_src || pull_low) |=> cpu_reset)
    else $error("reset released with a source active");
  chk_release_sync: assert property (@(posedge clock) disable iff (rst)
    $fell(cpu_reset) |->
      ($past(pin_sync) && !$past(pwr_hold) && !$past(int_src)))
    else $error("reset released while pin or source held");
  chk_vector_once: assert property (@(posedge clock) disable iff (rst)
    vector_load |=> !vector_load)
    else $error("vector load longer than one cycle");
  chk_vector_only: assert property (@(posedge clock) disable iff (rst)
    vector_load |-> (!cpu_reset && $past(cpu_reset)))
    else $error("vector load without a release");
  chk_wd_off: assert property (@(posedge clock) disable iff (rst)
    !options.watchdog_enable_option |=> !cause.watchdog)
    else $error("watchdog source not gated");
  chk_cause_wd: assert property (@(posedge clock) disable iff (rst)
    (watchdog_timeout && options.watchdog_enable_option) |=> cause.watchdog)
    else $error("watchdog cause not recorded");
  chk_cause_lv: assert property (@(posedge clock) disable iff (rst)
    (low_voltage_trip && options.low_voltage_enable_option) |=>
      (cpu_reset && cause.low_voltage))
    else $error("low-voltage trip missed");
  chk_prog_legal: assert property (@(posedge clock) disable iff (rst)
    (fetch.valid && fetch.addr >= 16'h0700 && fetch.addr <= 16'h1fff) |=> !cause.illegal_addr)
    else $error("legal program fetch flagged");
  chk_ram_legal: assert property (@(posedge clock) disable iff (rst)
    (fetch.valid && fetch.addr >= 16'h0020 && fetch.addr <= 16'h00ff) |=> !cause.illegal_addr)
    else $error("legal ram fetch flagged");
  chk_pulldown_end: assert property (@(posedge clock) disable iff (rst)
    (!int_src && !$past(int_src) && !$past(int_src, 2) && !$past(int_src, 3))
      |-> !reset_pin_n_oe)
    else $error("pulldown longer than four cycles");
  chk_oe_low: assert property (@(posedge clock) disable iff (rst)
    reset_pin_n_oe |-> !reset_pin_n_out)
    else $error("pulldown does not drive low");

  cov_power_up: cover property (@(posedge clock) disable iff (rst)
    state == ST_STAB ##1 state == ST_IDLE);
  cov_pin_reset: cover property (@(posedge clock) disable iff (rst) cause.pin);
  cov_watchdog: cover property (@(posedge clock) disable iff (rst) $rose(wd_src));
  cov_release: cover property (@(posedge clock) disable iff (rst) vector_load);
  cov_illegal_fetch: cover property (@(posedge clock) disable iff (rst)
    $rose(illegal_fetch));

endmodule
`default_nettype wire

// >>> testbench/rss_pin_model.sv
// Reset pin partner: push button or supervisor on the open-drain pin.
// Assumes a pull-up on the pin; its level feeds the sequencer input.
`timescale 1ns/1ps
`default_nettype none
module rss_pin_model (
  // Clock
  input wire logic clock,
  // Press request and device pulldown
  input wire logic press,
  input wire logic pull_low,
  input wire logic drive_n,
  // Pin level
  output logic pin_n
);
  logic [1:0] hold = 2'h0;
  // Any press keeps the pin low at least two more cycles
  always @(posedge clock) begin
    hold <= press ? 2'h2 : ((hold != 2'h0) ? hold - 2'h1 : 2'h0);
  end
  // Released pin returns high through the pull-up
  assign pin_n = !(press || hold != 2'h0 || (pull_low && !drive_n));
endmodule
`default_nettype wire

// >>> testbench/rss_sequencer_test.sv
// Self-checking bench for the reset source sequencer.
// Assumes the pin partner model and a 20 MHz bus clock.
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer_test;
  import rss_pkg::*;
  logic clock, rst, power_up_detect, osc_active, press, pin_n, oe, pin_out;
  logic watchdog_timeout, low_voltage_trip, cpu_reset, vector_load;
  rss_options_t options;
  rss_fetch_t fetch;
  rss_cause_t cause;
  int err_total = 0, total_checks = 0, cycles = 0, seed = 78;
  logic [15:0] corner [10] = '{16'h0000, 16'h001f, 16'h0020, 16'h00ff, 16'h0100,
    16'h06ff, 16'h0700, 16'h1fff, 16'h2000, 16'hffff};
  ////////////////////////////////////////////////////////////////////////////
  rss_sequencer i_dut (.clock(clock), .rst(rst), .power_up_detect(power_up_detect),
    .osc_active(osc_active), .options(options), .reset_pin_n_in(pin_n),
    .reset_pin_n_out(pin_out), .reset_pin_n_oe(oe), .watchdog_timeout(watchdog_timeout),
    .low_voltage_trip(low_voltage_trip), .fetch(fetch), .cpu_reset(cpu_reset),
    .vector_load(vector_load), .cause(cause));
  rss_pin_model i_pin (.clock(clock), .press(press), .pull_low(oe), .drive_n(pin_out),
    .pin_n(pin_n));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      results();
    end
  end
  task automatic chk_int(input string what, input int exp, input int got);
    total_checks++;
    if (exp != got) begin
      err_total++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  function automatic logic legal(input logic [15:0] a);
    return (a >= 16'h0700 && a <= 16'h1fff) || (a >= 16'h0020 && a <= 16'h00ff);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Internal source: 0 watchdog, 1 low voltage, 2 opcode fetch
  task automatic src(input int which, input logic en, input int len, input logic [15:0] a);
    int n_oe, n_vl, exp_oe;
    logic hit, seen, pinseen;
    n_oe = 0;
    n_vl = 0;
    seen = 1'b0;
    pinseen = 1'b0;
    hit = (which == 2) ? !legal(a) : en;
    exp_oe = hit ? ((len > 4) ? len : 4) : 0;
    options.watchdog_enable_option = en;
    options.low_voltage_enable_option = en;
    watchdog_timeout = (which == 0);
    low_voltage_trip = (which == 1);
    fetch = '{valid: (which == 2), addr: a};
    for (int i = 0; i < 40; i++) begin
      @(negedge clock);
      n_oe += (oe === 1'b1);
      n_vl += (vector_load === 1'b1);
      seen |= (cause[2 - which] === 1'b1 && cpu_reset === 1'b1);
      pinseen |= (cause.pin === 1'b1);
      @(posedge clock);
      #1;
      if (i == 0) begin
        fetch.valid = 1'b0;
      end
      if (i == len - 1) begin
        watchdog_timeout = 1'b0;
        low_voltage_trip = 1'b0;
      end
    end
    chk_int("pulldown cycles", exp_oe, n_oe);
    chk_bit("source reset", hit, seen);
    chk_bit("pin pulled by source", hit, pinseen);
    chk_int("vector loads", int'(hit), n_vl);
    chk_bit("reset released", 1'b0, cpu_reset);
  endtask
  // Power-up with nothing, the pin (1) or low voltage (2) held past the delay
  task automatic pwr(input logic lng, input int extra);
    int n, lim;
    logic pulled, pcause;
    lim = lng ? 4064 : 16;
    n = 0;
    pulled = 1'b0;
    pcause = 1'b0;
    options.long_delay = lng;
    options.low_voltage_enable_option = 1'b1;
    osc_active = 1'b0;
    power_up_detect = 1'b0;
    step(3);
    chk_bit("reset after supply drop", 1'b0, cpu_reset);
    power_up_detect = 1'b1;
    step(5);
    chk_bit("reset before oscillator", 1'b1, cpu_reset);
    osc_active = 1'b1;
    press = (extra == 1);
    low_voltage_trip = (extra == 2);
    if (extra != 0) begin
      step(lim + 10);
      chk_bit("reset held by source", 1'b1, cpu_reset);
      press = 1'b0;
      low_voltage_trip = 1'b0;
      lim = 0;
    end
    while (cpu_reset !== 1'b0 && n < 5000) begin
      @(negedge clock);
      pulled |= (oe === 1'b1);
      pcause |= (cause.power_up === 1'b1);
      n++;
    end
    chk_int("release window", 1, int'(n > lim && n <= lim + ((extra != 0) ? 8 : 3)));
    if (extra != 2) chk_bit("pulldown on power-up", 1'b0, pulled);
    if (extra == 0) chk_bit("power-up cause", 1'b1, pcause);
    step(1);
    $display("test power-up %0d %0d done", lng, extra);
  endtask
  task automatic pin(input int len);
    logic seen;
    seen = 1'b0;
    press = 1'b1;
    step(len);
    if (len > 4) chk_bit("reset while pin low", 1'b1, cpu_reset);
    press = 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(negedge clock);
      seen |= (cpu_reset === 1'b1 && cause.pin === 1'b1);
    end
    chk_bit("pin reset seen", 1'b1, seen);
    chk_bit("pin reset released", 1'b0, cpu_reset);
    step(1);
    $display("test pin %0d done", len);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int w, len;
    rst = 1'b1;
    power_up_detect = 1'b1;
    osc_active = 1'b0;
    press = 1'b0;
    options = '0;
    watchdog_timeout = 1'b0;
    low_voltage_trip = 1'b0;
    fetch = '0;
    step(20);
    rst = 1'b0;
    step(30);
    chk_bit("reset waits for oscillator", 1'b1, cpu_reset);
    osc_active = 1'b1;
    step(25);
    chk_bit("first release", 1'b0, cpu_reset);
    pwr(1'b0, 0);
    pwr(1'b1, 0);
    pwr(1'b0, 1);
    pwr(1'b0, 2);
    pin(1);
    pin(30);
    foreach (corner[i]) src(2, 1'b1, 1, corner[i]);
    src(0, 1'b0, 3, 16'h0000);
    src(0, 1'b1, 1, 16'h0000);
    src(1, 1'b0, 5, 16'h0000);
    src(1, 1'b1, 7, 16'h0000);
    $display("test corner sources done");
    repeat (16) begin
      w = $unsigned($random(seed)) % 3;
      len = (w == 2) ? 1 : 1 + $unsigned($random(seed)) % 8;
      src(w, 1'($random(seed)), len, 16'($random(seed)));
    end
    $display("test random sources done");
    results();
  end
endmodule
`default_nettype wire
